//--- logic/diag_monitor_pkg.sv
// Package: constants, enumerations and carriers of the diagnostic flag gating block
package diag_monitor_pkg;
	// Sizes
	localparam int SLOTS         = 8;
	localparam int LANES         = 8;
	localparam int VAL_W         = 16;
	localparam int OBS_W         = 5;
	localparam int LANE_W        = 3;
	localparam int FLAGS_PER_OBS = 4;
	localparam int AVG_SHIFT     = 4;

	// Feature advertisement and page span
	localparam logic [7:0] ADV_PAGE          = 8'h01;
	localparam logic [7:0] ADV_BYTE          = 8'h8E;
	localparam int         ADV_BIT           = 6;
	localparam logic [7:0] PAGE_FIRST        = 8'h20;
	localparam logic [7:0] PAGE_LAST         = 8'h2F;
	localparam logic       FEATURE_SUPPORTED = 1'h1;

	// Register byte offsets; slot groups hold one word per slot
	localparam logic [7:0] OFS_ADVERT = 8'h00;
	localparam logic [7:0] OFS_PAGES  = 8'h04;
	localparam logic [7:0] OFS_CTRL   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_FLAGS  = 8'h10;
	localparam logic [7:0] OFS_MASK   = 8'h14;
	localparam logic [7:0] OFS_DESC   = 8'h20;
	localparam logic [7:0] OFS_THR_HI = 8'h40;
	localparam logic [7:0] OFS_THR_LO = 8'h60;
	localparam logic [7:0] OFS_VALUE  = 8'h80;
	localparam logic [7:0] GROUP_MASK = 8'hE0;

	// Field positions
	localparam int ADV_BYTE_LSB   = 8;
	localparam int ADV_PAGE_LSB   = 16;
	localparam int PAGES_LAST_LSB = 8;
	localparam int CTRL_FREEZE    = 0;
	localparam int CTRL_ENABLE    = 1;
	localparam int STAT_IRQ       = 0;
	localparam int STAT_COUNT_LSB = 16;
	localparam int DESC_TYPE_LSB  = 0;
	localparam int DESC_LANE_LSB  = 8;
	localparam int THR_WARN_LSB   = 16;
	localparam int FLAG_HI_ALARM  = 0;
	localparam int FLAG_LO_ALARM  = 1;
	localparam int FLAG_HI_WARN   = 2;
	localparam int FLAG_LO_WARN   = 3;
	localparam int HTRANS_ACT     = 1;

	// Reset values; missing thresholds sit at the range ends so they never trip
	localparam logic [VAL_W-1:0] THR_HIGH_RST = 16'hFFFF;
	localparam logic [VAL_W-1:0] THR_LOW_RST  = 16'h0000;
	localparam logic             ENABLE_RST   = 1'h1;
	localparam logic [31:0]      MASK_RST     = 32'h0000_0000;

	// Path-state permission masks, bit index is the path_state_e position
	localparam logic [6:0] ALLOW_ALL       = 7'h7F;
	localparam logic [6:0] ALLOW_NOT_DEACT = 7'h7E;
	localparam logic [6:0] ALLOW_HOST_SNR  = 7'h7A;
	localparam logic [6:0] ALLOW_MEDIA     = 7'h7C;
	localparam logic [6:0] ALLOW_HOST_RATE = 7'h78;

	typedef enum logic [2:0] {
		MOD_RESET, MOD_MGMT_INIT, MOD_LOW_POWER, MOD_POWER_UP, MOD_READY, MOD_POWER_DOWN, MOD_FAULT
	} module_state_e;

	typedef enum logic [2:0] {
		PATH_DEACTIVATED_STATE, PATH_INITIALISING_STATE, PATH_DEINITIALISING_STATE,
		PATH_INITIALISED_STATE, PATH_TX_TURNING_ON_STATE, PATH_TX_TURNING_OFF_STATE,
		PATH_ACTIVATED_STATE
	} path_state_e;

	typedef enum logic [OBS_W-1:0] {
		OBS_NONE, OBS_LASER_AGE, OBS_COOLER_CURRENT, OBS_LASER_FREQ_ERROR, OBS_LASER_TEMP,
		OBS_SNR_MEDIA, OBS_SNR_HOST, OBS_LEVEL_TRANS_MEDIA, OBS_LEVEL_TRANS_HOST,
		OBS_BER_MEDIA_MIN, OBS_BER_MEDIA_MAX, OBS_BER_MEDIA_AVG, OBS_BER_MEDIA_CUR,
		OBS_BER_HOST_MIN, OBS_BER_HOST_MAX, OBS_BER_HOST_AVG, OBS_BER_HOST_CUR,
		OBS_FRAME_ERR_MEDIA_MIN, OBS_FRAME_ERR_MEDIA_MAX, OBS_FRAME_ERR_MEDIA_AVG, OBS_FRAME_ERR_MEDIA_CUR,
		OBS_FRAME_ERR_HOST_MIN, OBS_FRAME_ERR_HOST_MAX, OBS_FRAME_ERR_HOST_AVG, OBS_FRAME_ERR_HOST_CUR
	} obs_e;

	typedef struct packed {
		logic             valid;
		logic [VAL_W-1:0] value;
	} sample_s;

	typedef struct packed {
		logic             curValid;
		logic             frozen;
		logic [VAL_W-1:0] cur;
		logic [VAL_W-1:0] min;
		logic [VAL_W-1:0] max;
		logic [VAL_W-1:0] avg;
	} stats_s;
endpackage

//--- logic/stat_tracker.sv
// Interval statistics of one observable: current, minimum, maximum and average
module stat_tracker
(
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire diag_monitor_pkg::sample_s sample,
	input  wire logic                      freeze,
	output diag_monitor_pkg::stats_s       stats
);
	typedef struct packed {
		diag_monitor_pkg::stats_s                  out;
		logic                                      seen;
		logic                                      frzSeen;
		logic [diag_monitor_pkg::VAL_W-1:0]        runMin;
		logic [diag_monitor_pkg::VAL_W-1:0]        runMax;
		logic [diag_monitor_pkg::VAL_W-1:0]        runAvg;
	} state_s;

	state_s                                   q;
	state_s                                   d;
	logic signed [diag_monitor_pkg::VAL_W:0]  diff;
	logic signed [diag_monitor_pkg::VAL_W:0]  step;
	logic                                     first;

	// Average is a moving average, so no divider is needed at the interval end
	always_comb
	begin
		d = q;
		diff = $signed({1'b0, sample.value}) - $signed({1'b0, q.runAvg});
		step = diff >>> diag_monitor_pkg::AVG_SHIFT;
		first = freeze || !q.seen;
		d.out.curValid = sample.valid;
		d.out.frozen = freeze;
		if (freeze)
		begin
			d.out.min = q.runMin;
			d.out.max = q.runMax;
			d.out.avg = q.runAvg;
			d.frzSeen = q.seen;
			d.seen = 1'b0;
		end
		// A sample in the freeze cycle opens the next interval
		if (sample.valid)
		begin
			d.out.cur = sample.value;
			d.seen = 1'b1;
			if (first)
			begin
				d.runMin = sample.value;
				d.runMax = sample.value;
				d.runAvg = sample.value;
			end
			else
			begin
				d.runMin = (sample.value < q.runMin) ? sample.value : q.runMin;
				d.runMax = (sample.value > q.runMax) ? sample.value : q.runMax;
				d.runAvg = q.runAvg + step[diag_monitor_pkg::VAL_W-1:0];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			q <= '0;
		else
			q <= d;
	end

	assign stats = q.out;

	a_stats_order: assert property (@(posedge clk) disable iff (!rstn)
		stats.frozen && q.frzSeen |-> stats.min <= stats.avg && stats.avg <= stats.max)
		else $error("Interval statistics out of order");

	a_freeze_snap: assert property (@(posedge clk) disable iff (!rstn)
		freeze && q.seen |=> stats.frozen && stats.max == $past(q.runMax))
		else $error("Freeze did not capture the running maximum");
endmodule // stat_tracker

//--- logic/diag_monitor_flag_gating.sv
// Diagnostic monitor flag gating with AHB-Lite registers, statistics and interrupt
// Notes on behaviour
// - A flag never sets while its lane's path state forbids it.
// - No flag sets during module reset or management initialisation.
// - Otherwise each lane flag is gated by that lane's current path state.
// - Host mask bits may be written anytime; masked flags raise no interrupt.
// - Host SNR and host level transition flags forbidden when deactivated or deinitialising.
// - Media level transition flag forbidden when deactivated or initialising.
// - Media bit error ratio flags forbidden when deactivated or initialising.
// - Host bit error ratio flags only when initialised, turning on/off or activated.
// - Media frame error count flags forbidden when deactivated or initialising.
// - Host frame error count flags only when initialised, turning on/off or activated.
// - Feature support is advertised in one bit, position 6.
// - Feature spans pages 20h to 2Fh; 2Fh carries details and descriptors.
// - Error observables keep minimum, maximum and average per interval plus current.
// - Statistics intervals are bounded by host freeze requests, never a local tick.
// - Each observable carries high/low alarm and high/low warning flags.
// - Missing thresholds rest at the largest or smallest representable value.
module diag_monitor_flag_gating
(
	input  wire logic                                         clk,
	input  wire logic                                         rstn,
	input  wire logic                                         hsel,
	input  wire logic [31:0]                                  haddr,
	input  wire logic [1:0]                                   htrans,
	input  wire logic                                         hwrite,
	input  wire logic [2:0]                                   hsize,
	input  wire logic [31:0]                                  hwdata,
	input  wire logic                                         hready,
	output logic                                              hreadyout,
	output logic                                              hresp,
	output logic [31:0]                                       hrdata,
	input  wire diag_monitor_pkg::module_state_e              moduleState,
	input  wire diag_monitor_pkg::path_state_e                pathState [diag_monitor_pkg::LANES],
	input  wire diag_monitor_pkg::sample_s                    samples [diag_monitor_pkg::SLOTS],
	output logic                                              irq
);
	localparam int NF = diag_monitor_pkg::SLOTS * diag_monitor_pkg::FLAGS_PER_OBS;

	typedef logic [diag_monitor_pkg::SLOTS-1:0][diag_monitor_pkg::VAL_W-1:0] slot_val_t;

	typedef struct packed {
		logic                                                           ready;
		logic                                                           resp;
		logic                                                           wrPend;
		logic [7:0]                                                     wrAddr;
		logic [31:0]                                                    rdata;
		logic                                                           irq;
		logic                                                           freeze;
		logic                                                           enable;
		logic [15:0]                                                    freezeCount;
		logic [NF-1:0]                                                  flags;
		logic [NF-1:0]                                                  masks;
		logic [NF-1:0]                                                  flagsPrev;
		logic [diag_monitor_pkg::SLOTS-1:0][diag_monitor_pkg::OBS_W-1:0]  descType;
		logic [diag_monitor_pkg::SLOTS-1:0][diag_monitor_pkg::LANE_W-1:0] descLane;
		slot_val_t                                                      hiAlarm;
		slot_val_t                                                      hiWarn;
		slot_val_t                                                      loAlarm;
		slot_val_t                                                      loWarn;
		slot_val_t                                                      value;
	} state_s;

	state_s                                  q;
	state_s                                  d;
	logic                                    gateOpen;
	logic                                    accept;
	logic [NF-1:0]                           setEvt;
	logic [NF-1:0]                           clr;
	logic [diag_monitor_pkg::SLOTS-1:0]      permitted;
	logic [diag_monitor_pkg::SLOTS-1:0]      slotStb;
	logic [diag_monitor_pkg::VAL_W-1:0]      slotVal [diag_monitor_pkg::SLOTS];
	logic [NF-1:0]                           newFlags;

	// One clock domain: every check below samples on the rising edge and stays quiet in reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Path states in which each observable kind may set its flags
	function automatic logic [6:0] allowMask(input diag_monitor_pkg::obs_e t);
		unique case (t)
			diag_monitor_pkg::OBS_COOLER_CURRENT,
			diag_monitor_pkg::OBS_SNR_MEDIA:          return diag_monitor_pkg::ALLOW_ALL;
			diag_monitor_pkg::OBS_LASER_AGE,
			diag_monitor_pkg::OBS_LASER_FREQ_ERROR,
			diag_monitor_pkg::OBS_LASER_TEMP:         return diag_monitor_pkg::ALLOW_NOT_DEACT;
			diag_monitor_pkg::OBS_SNR_HOST,
			diag_monitor_pkg::OBS_LEVEL_TRANS_HOST:   return diag_monitor_pkg::ALLOW_HOST_SNR;
			diag_monitor_pkg::OBS_LEVEL_TRANS_MEDIA:  return diag_monitor_pkg::ALLOW_MEDIA;
			diag_monitor_pkg::OBS_BER_MEDIA_MIN, diag_monitor_pkg::OBS_BER_MEDIA_MAX,
			diag_monitor_pkg::OBS_BER_MEDIA_AVG, diag_monitor_pkg::OBS_BER_MEDIA_CUR:
				return diag_monitor_pkg::ALLOW_MEDIA;
			diag_monitor_pkg::OBS_FRAME_ERR_MEDIA_MIN, diag_monitor_pkg::OBS_FRAME_ERR_MEDIA_MAX,
			diag_monitor_pkg::OBS_FRAME_ERR_MEDIA_AVG, diag_monitor_pkg::OBS_FRAME_ERR_MEDIA_CUR:
				return diag_monitor_pkg::ALLOW_MEDIA;
			diag_monitor_pkg::OBS_BER_HOST_MIN, diag_monitor_pkg::OBS_BER_HOST_MAX,
			diag_monitor_pkg::OBS_BER_HOST_AVG, diag_monitor_pkg::OBS_BER_HOST_CUR:
				return diag_monitor_pkg::ALLOW_HOST_RATE;
			diag_monitor_pkg::OBS_FRAME_ERR_HOST_MIN, diag_monitor_pkg::OBS_FRAME_ERR_HOST_MAX,
			diag_monitor_pkg::OBS_FRAME_ERR_HOST_AVG, diag_monitor_pkg::OBS_FRAME_ERR_HOST_CUR:
				return diag_monitor_pkg::ALLOW_HOST_RATE;
			default:                                  return 7'h00;
		endcase
	endfunction

	// Register read view; unmapped words read as zero
	function automatic logic [31:0] readReg(input state_s s, input logic [7:0] a);
		logic [31:0] r;
		logic [2:0]  k;
		r = '0;
		k = a[4:2];
		if ((a & diag_monitor_pkg::GROUP_MASK) == diag_monitor_pkg::OFS_DESC)
		begin
			r[diag_monitor_pkg::DESC_TYPE_LSB +: diag_monitor_pkg::OBS_W] = s.descType[k];
			r[diag_monitor_pkg::DESC_LANE_LSB +: diag_monitor_pkg::LANE_W] = s.descLane[k];
		end
		else if ((a & diag_monitor_pkg::GROUP_MASK) == diag_monitor_pkg::OFS_THR_HI)
			r = {s.hiWarn[k], s.hiAlarm[k]};
		else if ((a & diag_monitor_pkg::GROUP_MASK) == diag_monitor_pkg::OFS_THR_LO)
			r = {s.loWarn[k], s.loAlarm[k]};
		else if ((a & diag_monitor_pkg::GROUP_MASK) == diag_monitor_pkg::OFS_VALUE)
			r[diag_monitor_pkg::VAL_W-1:0] = s.value[k];
		else
		begin
			case (a)
				diag_monitor_pkg::OFS_ADVERT:
				begin
					r[diag_monitor_pkg::ADV_BIT] = diag_monitor_pkg::FEATURE_SUPPORTED;
					r[diag_monitor_pkg::ADV_BYTE_LSB +: 8] = diag_monitor_pkg::ADV_BYTE;
					r[diag_monitor_pkg::ADV_PAGE_LSB +: 8] = diag_monitor_pkg::ADV_PAGE;
				end
				diag_monitor_pkg::OFS_PAGES:
				begin
					r[7:0] = diag_monitor_pkg::PAGE_FIRST;
					r[diag_monitor_pkg::PAGES_LAST_LSB +: 8] = diag_monitor_pkg::PAGE_LAST;
				end
				diag_monitor_pkg::OFS_CTRL:   r[diag_monitor_pkg::CTRL_ENABLE] = s.enable;
				diag_monitor_pkg::OFS_STATUS:
				begin
					r[diag_monitor_pkg::STAT_IRQ] = s.irq;
					r[diag_monitor_pkg::STAT_COUNT_LSB +: 16] = s.freezeCount;
				end
				diag_monitor_pkg::OFS_FLAGS:  r = s.flags;
				diag_monitor_pkg::OFS_MASK:   r = s.masks;
				default:                      r = '0;
			endcase
		end
		return r;
	endfunction

	// Reset and management initialisation hold every flag off
	assign gateOpen = q.enable && moduleState != diag_monitor_pkg::MOD_RESET
		&& moduleState != diag_monitor_pkg::MOD_MGMT_INIT;
	assign accept = hsel && hready && htrans[diag_monitor_pkg::HTRANS_ACT];

	// Per-slot statistics, selection of the flagged value and path-state qualification
	for (genvar i = 0; i < diag_monitor_pkg::SLOTS; i++)
	begin : g_slot
		diag_monitor_pkg::stats_s      st;
		diag_monitor_pkg::obs_e        typ;
		diag_monitor_pkg::path_state_e laneSt;
		logic [6:0]                    am;
		logic                          isMin;
		logic                          isMax;
		logic                          isAvg;

		stat_tracker u_stat
		(
			.clk    (clk),
			.rstn   (rstn),
			.sample (samples[i]),
			.freeze (q.freeze),
			.stats  (st)
		);

		assign typ = diag_monitor_pkg::obs_e'(q.descType[i]);
		assign laneSt = pathState[q.descLane[i]];
		assign am = allowMask(typ);
		assign permitted[i] = gateOpen && am[laneSt];
		assign isMin = typ inside {diag_monitor_pkg::OBS_BER_MEDIA_MIN, diag_monitor_pkg::OBS_BER_HOST_MIN,
			diag_monitor_pkg::OBS_FRAME_ERR_MEDIA_MIN, diag_monitor_pkg::OBS_FRAME_ERR_HOST_MIN};
		assign isMax = typ inside {diag_monitor_pkg::OBS_BER_MEDIA_MAX, diag_monitor_pkg::OBS_BER_HOST_MAX,
			diag_monitor_pkg::OBS_FRAME_ERR_MEDIA_MAX, diag_monitor_pkg::OBS_FRAME_ERR_HOST_MAX};
		assign isAvg = typ inside {diag_monitor_pkg::OBS_BER_MEDIA_AVG, diag_monitor_pkg::OBS_BER_HOST_AVG,
			diag_monitor_pkg::OBS_FRAME_ERR_MEDIA_AVG, diag_monitor_pkg::OBS_FRAME_ERR_HOST_AVG};
		// Statistic kinds are judged once per host interval, the rest per sample
		assign slotStb[i] = (isMin || isMax || isAvg) ? st.frozen : st.curValid;
		assign slotVal[i] = isMin ? st.min : isMax ? st.max : isAvg ? st.avg : st.cur;
		// Four threshold crossings per observable, strictly outward
		assign setEvt[i*4 +: 4] = (slotStb[i] && permitted[i]) ? {
			slotVal[i] < q.loWarn[i], slotVal[i] > q.hiWarn[i],
			slotVal[i] < q.loAlarm[i], slotVal[i] > q.hiAlarm[i]} : 4'h0;

		a_no_flag_closed: assert property (
			!permitted[i] |=> (newFlags[i*4 +: 4] == 4'h0))
			else $error("Flag set in a forbidden path state");
		a_lane_sets_hi: assert property (
			slotStb[i] && permitted[i] && slotVal[i] > q.hiAlarm[i] |=> q.flags[i*4 + diag_monitor_pkg::FLAG_HI_ALARM])
			else $error("Permitted high alarm crossing not flagged");
		a_host_snr_off: assert property (
			(typ inside {diag_monitor_pkg::OBS_SNR_HOST, diag_monitor_pkg::OBS_LEVEL_TRANS_HOST})
			&& (laneSt inside {diag_monitor_pkg::PATH_DEACTIVATED_STATE, diag_monitor_pkg::PATH_DEINITIALISING_STATE})
			|-> !permitted[i])
			else $error("Host SNR flag permitted in a closed state");
		a_media_lvl_off: assert property (
			typ == diag_monitor_pkg::OBS_LEVEL_TRANS_MEDIA && laneSt == diag_monitor_pkg::PATH_INITIALISING_STATE
			|-> !permitted[i])
			else $error("Media level transition flag permitted while initialising");
		a_host_rate_off: assert property (
			(typ inside {diag_monitor_pkg::OBS_BER_HOST_CUR, diag_monitor_pkg::OBS_FRAME_ERR_HOST_AVG})
			&& laneSt == diag_monitor_pkg::PATH_DEINITIALISING_STATE |-> !permitted[i])
			else $error("Host error-rate flag permitted while deinitialising");
		a_lane_sets_lo: assert property (
			slotStb[i] && permitted[i] && slotVal[i] < q.loAlarm[i] |=> q.flags[i*4 + diag_monitor_pkg::FLAG_LO_ALARM])
			else $error("Permitted low alarm crossing not flagged");
		a_laser_off: assert property (
			(typ inside {diag_monitor_pkg::OBS_LASER_AGE, diag_monitor_pkg::OBS_LASER_FREQ_ERROR,
			diag_monitor_pkg::OBS_LASER_TEMP}) && laneSt == diag_monitor_pkg::PATH_DEACTIVATED_STATE
			|-> !permitted[i])
			else $error("Laser flag permitted while deactivated");
		a_media_rate_off: assert property (
			(typ inside {diag_monitor_pkg::OBS_BER_MEDIA_CUR, diag_monitor_pkg::OBS_FRAME_ERR_MEDIA_CUR})
			&& (laneSt inside {diag_monitor_pkg::PATH_DEACTIVATED_STATE, diag_monitor_pkg::PATH_INITIALISING_STATE})
			|-> !permitted[i])
			else $error("Media error-rate flag permitted while deactivated or initialising");
	end

	// Bus phases, register writes and flag bookkeeping
	always_comb
	begin
		d = q;
		clr = '0;
		d.freeze = 1'b0;
		d.wrPend = accept && hwrite;
		if (accept && hwrite)
			d.wrAddr = haddr[7:0];
		if (accept && !hwrite)
			d.rdata = readReg(q, haddr[7:0]);
		// Writes land in the data phase, when hwdata stands
		if (q.wrPend)
		begin
			if ((q.wrAddr & diag_monitor_pkg::GROUP_MASK) == diag_monitor_pkg::OFS_DESC)
			begin
				d.descType[q.wrAddr[4:2]] = hwdata[diag_monitor_pkg::DESC_TYPE_LSB +: diag_monitor_pkg::OBS_W];
				d.descLane[q.wrAddr[4:2]] = hwdata[diag_monitor_pkg::DESC_LANE_LSB +: diag_monitor_pkg::LANE_W];
			end
			else if ((q.wrAddr & diag_monitor_pkg::GROUP_MASK) == diag_monitor_pkg::OFS_THR_HI)
			begin
				d.hiAlarm[q.wrAddr[4:2]] = hwdata[diag_monitor_pkg::VAL_W-1:0];
				d.hiWarn[q.wrAddr[4:2]] = hwdata[diag_monitor_pkg::THR_WARN_LSB +: diag_monitor_pkg::VAL_W];
			end
			else if ((q.wrAddr & diag_monitor_pkg::GROUP_MASK) == diag_monitor_pkg::OFS_THR_LO)
			begin
				d.loAlarm[q.wrAddr[4:2]] = hwdata[diag_monitor_pkg::VAL_W-1:0];
				d.loWarn[q.wrAddr[4:2]] = hwdata[diag_monitor_pkg::THR_WARN_LSB +: diag_monitor_pkg::VAL_W];
			end
			else
			begin
				case (q.wrAddr)
					diag_monitor_pkg::OFS_CTRL:
					begin
						d.freeze = hwdata[diag_monitor_pkg::CTRL_FREEZE];
						d.enable = hwdata[diag_monitor_pkg::CTRL_ENABLE];
					end
					diag_monitor_pkg::OFS_FLAGS: clr = hwdata;
					diag_monitor_pkg::OFS_MASK:  d.masks = hwdata;
					default:                     ;
				endcase
			end
		end
		if (q.freeze)
			d.freezeCount = q.freezeCount + 16'h0001;
		// A crossing in the clearing cycle survives: set beats clear
		d.flags = (q.flags & ~clr) | setEvt;
		d.flagsPrev = q.flags;
		for (int i = 0; i < diag_monitor_pkg::SLOTS; i++)
			if (slotStb[i])
				d.value[i] = slotVal[i];
		d.irq = |(d.flags & ~d.masks);
	end

	// Thresholds start at the range ends so an unwritten pair never trips
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.ready <= 1'b1;
			q.enable <= diag_monitor_pkg::ENABLE_RST;
			q.masks <= diag_monitor_pkg::MASK_RST;
			q.hiAlarm <= {diag_monitor_pkg::SLOTS{diag_monitor_pkg::THR_HIGH_RST}};
			q.hiWarn <= {diag_monitor_pkg::SLOTS{diag_monitor_pkg::THR_HIGH_RST}};
			q.loAlarm <= {diag_monitor_pkg::SLOTS{diag_monitor_pkg::THR_LOW_RST}};
			q.loWarn <= {diag_monitor_pkg::SLOTS{diag_monitor_pkg::THR_LOW_RST}};
		end
		else
			q <= d;
	end

	assign hreadyout = q.ready;
	assign hresp = q.resp;
	assign hrdata = q.rdata;
	assign irq = q.irq;

	// Helper for the checks: bits that rose at the last edge
	assign newFlags = q.flags & ~q.flagsPrev;

	sequence rdAdvert;
		accept && !hwrite && haddr[7:0] == diag_monitor_pkg::OFS_ADVERT;
	endsequence
	sequence freezeWr;
		q.wrPend && q.wrAddr == diag_monitor_pkg::OFS_CTRL && hwdata[diag_monitor_pkg::CTRL_FREEZE];
	endsequence
	sequence freezeSeen;
		q.freeze ##1 g_slot[0].st.frozen;
	endsequence

	a_gate_mgmt: assert property (
		(moduleState inside {diag_monitor_pkg::MOD_RESET, diag_monitor_pkg::MOD_MGMT_INIT}) |=> newFlags == '0)
		else $error("Flag set during reset or management initialisation");
	a_mask_irq: assert property (
		q.irq == |(q.flags & ~q.masks))
		else $error("Interrupt does not follow unmasked flags");
	a_advert_read: assert property (
		rdAdvert |=> hrdata[diag_monitor_pkg::ADV_BIT] == diag_monitor_pkg::FEATURE_SUPPORTED)
		else $error("Feature advertisement bit wrong");
	a_freeze_host: assert property (
		freezeWr |=> freezeSeen)
		else $error("Host freeze did not close the interval");
	a_no_self_tick: assert property (
		q.freeze |-> $past(q.wrPend))
		else $error("Interval closed without a host request");
	a_flag_sticky: assert property (
		q.flags[0] && !(q.wrPend && q.wrAddr == diag_monitor_pkg::OFS_FLAGS) |=> q.flags[0])
		else $error("Flag dropped without a clear");
	a_clear_w1c: assert property (
		q.wrPend && q.wrAddr == diag_monitor_pkg::OFS_FLAGS && hwdata[0] && !setEvt[0] |=> !q.flags[0])
		else $error("Written one did not clear the flag");
	a_mask_hold: assert property (
		q.wrPend && q.wrAddr == diag_monitor_pkg::OFS_MASK |=> q.masks == $past(hwdata))
		else $error("Mask write did not land");
	a_enable_gate: assert property (
		!q.enable |=> newFlags == '0)
		else $error("Flag set while monitoring is disabled");
	a_ready_ok: assert property (
		hreadyout && !hresp)
		else $error("Slave stalled or answered with error");
endmodule // diag_monitor_flag_gating

//--- tb/host_model.sv
// AHB-Lite host model: single word transfers to the block registers
module host_model
(
	input  wire logic   clk,
	input  wire logic   hready,
	output logic [31:0] haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [31:0] hwdata
);
	timeunit 1ns / 1ps;
	// Bus idles until the first transfer
	initial {haddr, htrans, hwrite, hwdata} = '0;
	// Holds each phase until hready is high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'h1);
	endtask
endmodule // host_model

//--- tb/testbench.sv
// Self-checking bench of the flag gating block
module testbench;
	timeunit 1ns / 1ps;
	logic                            clk = 1'h0, rstn = 1'h0, hwrite, hreadyout, hresp, irq;
	logic [1:0]                      htrans;
	logic [31:0]                     haddr, hwdata, hrdata;
	diag_monitor_pkg::module_state_e moduleState = diag_monitor_pkg::MOD_READY;
	diag_monitor_pkg::path_state_e   pathState [8] = '{default: diag_monitor_pkg::PATH_ACTIVATED_STATE};
	diag_monitor_pkg::sample_s       samples [8] = '{default: 17'h00000};
	int                              errCount = 0, checkCount = 0;
	// Rows: module state, mask, kind, path state, flag expected
	logic [23:0]                     rows [23] = '{
		24'h400100, 24'h400111, 24'h400201, 24'h400400, 24'h400331, 24'h400501, 24'h400620, 24'h400611, 24'h400710,
		24'h400721, 24'h400820, 24'h400C10, 24'h400C21, 24'h401020, 24'h401041, 24'h401400, 24'h401461, 24'h401810,
		24'h401851, 24'h410561, 24'h000560, 24'h100560, 24'h400A60};
	host_model i_host (.clk, .hready(hreadyout), .haddr, .htrans, .hwrite, .hwdata);
	diag_monitor_flag_gating i_dut (.clk, .rstn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .moduleState, .pathState, .samples, .irq);
	// Clock, and a watchdog against a hang
	initial forever #5 clk = ~clk;
	initial #50us closeOut(1);
	task automatic closeOut(input int extra);
		errCount += extra;
		$display("checks %0d mismatches %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [32:0] want);
		i_host.xfer(1'h0, a, 32'h00000000);
		checkCount++;
		if ({hresp, irq, hrdata} !== {1'h0, want})
		begin
			errCount++;
			$display("BAD t=%0t addr %0h got %0h", $time, a, {hresp, irq, hrdata});
		end
	endtask
	// Reset, register map, gating table, then one host-timed interval
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'h1;
		repeat (2) @(posedge clk);
		rdChk(8'h00, 33'h000018E40);
		rdChk(8'h04, 33'h000002F20);
		rdChk(8'h40, 33'h0FFFFFFFF);
		rdChk(8'h60, 33'h000000000);
		rdChk(8'hFC, 33'h000000000);
		i_host.xfer(1'h1, 8'h40, 32'h00000000); // High limits of slot 0 at zero: a value of one crosses
		$display("register test done");
		// Per row: set states, one sample, check, clear
		foreach (rows[i])
		begin
			moduleState <= diag_monitor_pkg::module_state_e'(rows[i][22:20]);
			pathState[0] <= diag_monitor_pkg::path_state_e'(rows[i][6:4]);
			i_host.xfer(1'h1, 8'h20, {27'h0000000, rows[i][12:8]});
			i_host.xfer(1'h1, 8'h14, {29'h00000000, rows[i][16], 1'h0, rows[i][16]});
			samples[0] <= 17'h10001;
			@(posedge clk);
			samples[0] <= 17'h00001;
			repeat (3) @(posedge clk);
			rdChk(8'h10, {rows[i][0] & ~rows[i][16], 29'h00000000, rows[i][0], 1'h0, rows[i][0]});
			i_host.xfer(1'h1, 8'h10, 32'h0000000F);
		end
		$display("gating table done");
		i_host.xfer(1'h1, 8'h08, 32'h00000003);
		repeat (2) @(posedge clk);
		rdChk(8'h10, 33'h100000005);
		$display("freeze test done");
		// Gate off then on, slot 0 on an always allowed kind with both low limits at two
		i_host.xfer(1'h1, 8'h10, 32'h0000000F);
		i_host.xfer(1'h1, 8'h08, 32'h00000000);
		i_host.xfer(1'h1, 8'h20, 32'h00000005);
		i_host.xfer(1'h1, 8'h60, 32'h00020002);
		for (int e = 0; e < 2; e++)
		begin
			samples[0] <= 17'h10001;
			@(posedge clk);
			samples[0] <= 17'h00001;
			repeat (3) @(posedge clk);
			rdChk(8'h10, e ? 33'h10000000F : 33'h000000000);
			i_host.xfer(1'h1, 8'h08, 32'h00000002);
		end
		rdChk(8'h0C, 33'h100010001);
		rdChk(8'h80, 33'h100000001);
		// Reset in mid-run drops flags, interrupt and written limits
		rstn <= 1'h0;
		repeat (5) @(posedge clk);
		rstn <= 1'h1;
		repeat (2) @(posedge clk);
		rdChk(8'h10, 33'h000000000);
		rdChk(8'h60, 33'h000000000);
		rdChk(8'h08, 33'h000000002);
		$display("gate and reset test done");
		closeOut(0);
	end
endmodule // testbench
